// ==== hdl/rio_irq.sv ====
// Purpose: merges rtc interrupt sources onto one open-drain low pin
// Assumes: event inputs are one-cycle mclk pulses; clears are one-cycle
// Notes: flag set wins over a clear in the same cycle
`include "rio_regs.svh"
module rio_irq #(
  parameter int WIDTH_W = 20,
  parameter int CD_W = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input rio_pkg::rio_cfg_t cfg,
  input rio_pkg::rio_clr_t host_clr,
  input wire logic sec_inc,
  input wire logic min_inc,
  input wire logic countdown_event,
  input wire logic [CD_W-1:0] countdown_value,
  input wire logic alarm_event,
  input wire logic stamp_event,
  input wire logic switchover_event,
  input wire logic watchdog_event,
  input wire logic watchdog_service,
  input wire logic battery_low,
  output rio_pkg::rio_flags_t flags,
  output logic int_out,
  output logic int_oe
);
  import rio_pkg::*;

  // ----------------------------------------------------------------
  // tick and countdown event selection
  // ----------------------------------------------------------------
  wire logic tick_event = cfg.per_1s_enable ? sec_inc
                        : (cfg.per_60s_enable & min_inc); // [R7] [R8]
  wire logic cd_running = (countdown_value != '0); // [R13]
  wire logic cd_set = countdown_event & cd_running;
  wire logic n_is_one = (countdown_value == {{(CD_W-1){1'b0}}, 1'b1});

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  rio_flags_t next_flags;
  always_comb begin
    next_flags = flags;
    // set wins over clear [R4]
    next_flags.tick_flag = tick_event | (flags.tick_flag & ~host_clr.tick);
    next_flags.countdown_flag = cd_set
      | (flags.countdown_flag & ~host_clr.countdown);
    next_flags.alarm_flag = alarm_event
      | (flags.alarm_flag & ~host_clr.alarm);
    next_flags.stamp_flags = stamp_event
      | (flags.stamp_flags & ~host_clr.stamp);
    next_flags.switchover_flag = switchover_event
      | (flags.switchover_flag & ~host_clr.switchover);
    // host clears ignored here, only service clears it [R5]
    next_flags.watchdog_flag = watchdog_event
      | (flags.watchdog_flag & ~watchdog_service);
    next_flags.battery_low_flag = battery_low; // [R6]
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // pulse widths
  // ----------------------------------------------------------------
  localparam logic [WIDTH_W-1:0] W64 = WIDTH_W'(`RIO_CYC_64);
  localparam logic [WIDTH_W-1:0] W128 = WIDTH_W'(`RIO_CYC_128);
  localparam logic [WIDTH_W-1:0] W4096 = WIDTH_W'(`RIO_CYC_4096);
  localparam logic [WIDTH_W-1:0] W8192 = WIDTH_W'(`RIO_CYC_8192);
  wire logic [WIDTH_W-1:0] cd_width =
    (cfg.countdown_src == `RIO_SRC_4096) ? (n_is_one ? W8192 : W4096) :
    (cfg.countdown_src == `RIO_SRC_64) ? (n_is_one ? W128 : W64) :
    W64; // [R12]

  logic tick_pulse;
  logic cd_pulse;

  rio_pulse #(.WIDTH_W(WIDTH_W)) u_tick_pulse (
    .mclk(mclk),
    .rstn(rstn),
    .start(tick_event & cfg.pulse_select), // [R9]
    .abort(host_clr.tick), // [R14]
    .width(W64), // [R10]
    .active(tick_pulse)
  );

  rio_pulse #(.WIDTH_W(WIDTH_W)) u_cd_pulse (
    .mclk(mclk),
    .rstn(rstn),
    .start(cd_set & cfg.pulse_select & cfg.countdown_irq_en), // [R11]
    .abort(host_clr.countdown), // [R14]
    .width(cd_width),
    .active(cd_pulse)
  );

  // ----------------------------------------------------------------
  // merge
  // ----------------------------------------------------------------
  wire logic tick_en = cfg.per_1s_enable | cfg.per_60s_enable;
  // both tick enables off silences a pulse already under way too
  wire logic tick_req = tick_en
    & (cfg.pulse_select ? tick_pulse : flags.tick_flag); // [R3] [R7] [R9]
  wire logic cd_req = cfg.countdown_irq_en
    & (cfg.pulse_select ? cd_pulse : flags.countdown_flag); // [R11]
  wire logic wd_req = (cfg.watchdog_irq_select != `RIO_WD_OFF)
    & flags.watchdog_flag; // [R15]
  wire logic al_req = cfg.alarm_irq_en & flags.alarm_flag; // [R16]
  wire logic ts_req = cfg.stamp_irq_en & flags.stamp_flags; // [R17]
  wire logic bs_req = cfg.switchover_irq_en & flags.switchover_flag; // [R18]
  wire logic bl_req = cfg.lowbatt_irq_en & flags.battery_low_flag; // [R19]
  wire logic any_req = tick_req | cd_req | wd_req | al_req | ts_req
    | bs_req | bl_req; // [R20] [R2]

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      int_oe <= 1'b0;
    end else begin
      int_oe <= any_req; // [R1]
    end
  end

  // open-drain: only ever drives low
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      int_out <= 1'b0;
    end else begin
      int_out <= 1'b0; // [R1]
    end
  end
endmodule // rio_irq

// ==== hdl/rio_regs.svh ====
// Purpose: constants for the rtc interrupt output block
// Assumes: mclk at 40 MHz; second, minute and countdown ticks arrive as mclk pulses
// Notes: every count below is in mclk cycles unless stated
// How it works
// R1: one active-low open-drain interrupt pin, pulled low or released.
// R2: with every source disabled the pin stays released.
// R3: pulse_select picks pulse or level for tick and countdown; others level.
// R4: tick, countdown, alarm, stamp and switchover flags clear on host write.
// R5: host writes never clear watchdog_flag; only watchdog service does.
// R6: battery_low_flag is read-only; the detector clears it.
// R7: per_60s/per_1s enables pick none, minute or second ticks.
// R8: tick_flag sets on minute or second increment as enabled.
// R9: tick pulse when pulse_select is 1, else level until cleared.
// R10: tick pulse lasts one period of the 64 Hz clock.
// R11: countdown_irq_en enables countdown pulse or level per pulse_select.
// R12: countdown pulse width set by source clock and loaded value n.
// R13: loaded value zero stops the countdown, no interrupts.
// R14: clearing tick or countdown flag ends its pulse at once.
// R15: watchdog interrupt is a level following watchdog_flag when selected.
// R16: alarm interrupt follows alarm_flag as a level.
// R17: stamp interrupt follows stamp_flags as a level.
// R18: switchover interrupt follows switchover_flag as a level.
// R19: lowbatt interrupt follows battery_low_flag, released by flag or enable.
// R20: pin pulled low when any enabled level or pulse is active.
`ifndef RIO_REGS_SVH
`define RIO_REGS_SVH

`define RIO_MCLK_HZ 40000000
// pulse widths as divisors of one second
`define RIO_DIV_8192 8192
`define RIO_DIV_4096 4096
`define RIO_DIV_128 128
`define RIO_DIV_64 64
`define RIO_CYC_8192 (`RIO_MCLK_HZ / `RIO_DIV_8192)
`define RIO_CYC_4096 (`RIO_MCLK_HZ / `RIO_DIV_4096)
`define RIO_CYC_128 (`RIO_MCLK_HZ / `RIO_DIV_128)
`define RIO_CYC_64 (`RIO_MCLK_HZ / `RIO_DIV_64)
// countdown source clock codes
`define RIO_SRC_4096 2'h0
`define RIO_SRC_64 2'h1
`define RIO_SRC_1 2'h2
`define RIO_SRC_60 2'h3
`define RIO_WD_OFF 2'h0

`endif

// ==== hdl/rio_pkg.sv ====
// Purpose: types shared by the rtc interrupt output block
// Assumes: nothing
// Notes: config, clear and flag groups travel as packed structs
package rio_pkg;
  typedef struct packed {
    logic tick;
    logic countdown;
    logic alarm;
    logic stamp;
    logic switchover;
  } rio_clr_t;

  typedef struct packed {
    logic per_60s_enable;
    logic per_1s_enable;
    logic pulse_select;
    logic countdown_irq_en;
    logic [1:0] watchdog_irq_select;
    logic alarm_irq_en;
    logic stamp_irq_en;
    logic switchover_irq_en;
    logic lowbatt_irq_en;
    logic [1:0] countdown_src;
  } rio_cfg_t;

  typedef struct packed {
    logic tick_flag;
    logic countdown_flag;
    logic watchdog_flag;
    logic alarm_flag;
    logic stamp_flags;
    logic switchover_flag;
    logic battery_low_flag;
  } rio_flags_t;

  typedef enum logic {RIO_IDLE, RIO_PULSE} rio_pstate_t;
endpackage

// ==== hdl/rio_pulse.sv ====
// Purpose: one interrupt pulse generator with early termination
// Assumes: width loaded on start is at least one cycle
// Notes: start wins over an abort in the same cycle
`include "rio_regs.svh"
module rio_pulse #(
  parameter int WIDTH_W = 20
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic start,
  input wire logic abort,
  input wire logic [WIDTH_W-1:0] width,
  output logic active
);
  import rio_pkg::*;
  rio_pstate_t state;
  logic [WIDTH_W-1:0] count;
  wire logic last = (count == {{(WIDTH_W-1){1'b0}}, 1'b1});

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= RIO_IDLE;
      count <= '0;
    end else if (start) begin
      state <= RIO_PULSE;
      count <= width;
    end else begin
      case (state)
        RIO_IDLE: count <= '0;
        RIO_PULSE: begin
          if (abort || last) begin
            state <= RIO_IDLE; // [R14]
          end
          count <= count - 1'b1;
        end
        default: state <= RIO_IDLE;
      endcase
    end
  end

  assign active = (state == RIO_PULSE);
endmodule // rio_pulse

// ==== dv/rio_irq_chk.sv ====
// Purpose: port-level checks of the interrupt merge block
// Assumes: bound to rio_irq; one clock, async low reset
// Notes: exact countdown pulse widths at the 4096 Hz source are measured by the bench
module rio_irq_chk #(
  parameter int CD_W = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input rio_pkg::rio_cfg_t cfg,
  input wire logic sec_inc,
  input wire logic countdown_event,
  input wire logic [CD_W-1:0] countdown_value,
  input wire logic watchdog_service,
  input wire logic battery_low,
  input rio_pkg::rio_flags_t flags,
  input wire logic int_out,
  input wire logic int_oe
);
  import rio_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire logic wd_en = |cfg.watchdog_irq_select;
  wire logic tk_en = cfg.per_60s_enable | cfg.per_1s_enable;
  wire logic any_en = tk_en | cfg.countdown_irq_en | wd_en | cfg.alarm_irq_en
    | cfg.stamp_irq_en | cfg.switchover_irq_en | cfg.lowbatt_irq_en;
  wire logic lvl = (flags.tick_flag & tk_en)
    | (flags.countdown_flag & cfg.countdown_irq_en)
    | (flags.watchdog_flag & wd_en) | (flags.alarm_flag & cfg.alarm_irq_en)
    | (flags.stamp_flags & cfg.stamp_irq_en)
    | (flags.switchover_flag & cfg.switchover_irq_en)
    | (flags.battery_low_flag & cfg.lowbatt_irq_en);
  sequence tick_start_s;
    cfg.pulse_select && cfg.per_1s_enable && sec_inc;
  endsequence
  sequence cd_start_s;
    cfg.pulse_select && cfg.countdown_irq_en && countdown_event
      && (countdown_value != '0);
  endsequence
  pin_low_a: assert property (!int_out)
    else $error("pin driven high");
  all_off_a: assert property (!any_en ##1 !any_en |-> !int_oe)
    else $error("pin pulled with all sources off");
  lvl_merge_a: assert property (!cfg.pulse_select && $past(!cfg.pulse_select)
    |-> int_oe == $past(lvl))
    else $error("level merge wrong");
  wd_hold_a: assert property (flags.watchdog_flag && !watchdog_service
    |=> flags.watchdog_flag)
    else $error("watchdog flag lost");
  blf_copy_a: assert property (1 |=> flags.battery_low_flag
    == $past(battery_low))
    else $error("battery low flag not tracking");
  sec_tick_a: assert property (sec_inc && cfg.per_1s_enable
    |=> flags.tick_flag)
    else $error("tick flag missed");
  cd_zero_a: assert property (countdown_value == '0 && !flags.countdown_flag
    |=> !flags.countdown_flag)
    else $error("countdown ran at zero");
  cd_pulse_a: assert property (cd_start_s |-> ##2 int_oe)
    else $error("countdown pulse missing");
  tick_pulse_a: assert property (tick_start_s |-> ##2 int_oe)
    else $error("tick pulse missing");
endmodule // rio_irq_chk

// ==== dv/rio_host.sv ====
// Purpose: host interrupt input behind the pin pull-up
// Assumes: pin released reads high
// Notes: none
module rio_host (
  input wire logic int_out,
  input wire logic int_oe,
  output logic irq_n
);
  timeunit 1ns;
  timeprecision 100ps;
  assign irq_n = int_oe ? int_out : 1'b1;
endmodule // rio_host

// ==== dv/tb.sv ====
// Purpose: self-checking bench for rio_irq
// Assumes: inputs change 2 ns after the rising edge
// Notes: long pulses are checked by early clearing or disabling, except countdown pulses at the 4096 Hz source, which are timed in full
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rio_pkg::*;
  logic mclk = 0, rstn = 0, bat = 0, wsrv = 0, int_out, int_oe, irq_n;
  logic [6:0] ev = '0;
  logic [7:0] n = 8'h01;
  rio_cfg_t cfg = '0;
  rio_clr_t clr = '0;
  rio_flags_t flags;
  int n_errors = 0, compares = 0, w;
  always #12.5 mclk = ~mclk;
  rio_irq i_dut (.mclk(mclk), .rstn(rstn), .cfg(cfg), .host_clr(clr),
    .sec_inc(ev[0]), .min_inc(ev[1]), .countdown_event(ev[2]),
    .countdown_value(n), .alarm_event(ev[3]), .stamp_event(ev[4]),
    .switchover_event(ev[5]), .watchdog_event(ev[6]),
    .watchdog_service(wsrv), .battery_low(bat), .flags(flags),
    .int_out(int_out), .int_oe(int_oe));
  rio_host i_host (.int_out(int_out), .int_oe(int_oe), .irq_n(irq_n));
  task automatic step(int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask
  task automatic fire(int b);
    ev[b] = 1'b1;
    step(1);
    ev[b] = 1'b0;
    step(1);
  endtask
  task automatic clear(rio_clr_t c);
    clr = c;
    step(1);
    clr = '0;
    step(2);
  endtask
  task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %0h seen %0h", s, exp, seen);
    end
  endtask
  function automatic int exp_w(logic [7:0] v);
    return (v == 8'h01) ? 40000000 / 8192 : 40000000 / 4096;
  endfunction
  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    n_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(32'hA6DA));
    step(5);
    rstn = 1'b1;
    step(1);
    chk("pin_idle", irq_n, 1);
    cfg = 12'h038;
    for (int i = 3; i < 6; i++) begin
      step($urandom_range(5, 1));
      fire(i);
      chk("lvl_on", irq_n, 0);
      clear(5'(1 << (5 - i)));
      chk("lvl_off", irq_n, 1);
    end
    cfg = '0;
    cfg.watchdog_irq_select = 2'h1;
    fire(6);
    clear('1);
    chk("wd_ro", flags.watchdog_flag, 1);
    chk("wd_on", irq_n, 0);
    wsrv = 1'b1;
    step(1);
    wsrv = 1'b0;
    step(2);
    chk("wd_off", irq_n, 1);
    cfg = '0;
    cfg.lowbatt_irq_en = 1'b1;
    bat = 1'b1;
    step(3);
    clear('1);
    chk("bl_on", irq_n, 0);
    cfg.lowbatt_irq_en = 1'b0;
    step(2);
    chk("bl_en_off", irq_n, 1);
    bat = 1'b0;
    step(2);
    chk("bl_flag", flags.battery_low_flag, 0);
    $display("levels done");
    cfg.per_60s_enable = 1'b1;
    fire(0);
    chk("no_sec", flags.tick_flag, 0);
    fire(1);
    chk("min_tick", irq_n, 0);
    clear(5'h10);
    chk("tick_clr", irq_n, 1);
    cfg.per_60s_enable = 1'b0;
    fire(0);
    fire(1);
    chk("tick_none", flags.tick_flag, 0);
    $display("tick done");
    cfg.pulse_select = 1'b1;
    cfg.countdown_irq_en = 1'b1;
    n = 8'h00;
    fire(2);
    chk("cd_zero", irq_n, 1);
    for (int k = 0; k < 2; k++) begin
      n = k ? 8'($urandom_range(255, 2)) : 8'h01;
      fire(2);
      w = 0;
      while (int_oe === 1'b1 && w < 20000) begin
        w++;
        step(1);
      end
      chk("cd_width", w, exp_w(n));
      clear(5'h08);
    end
    cfg.countdown_src = 2'($urandom_range(3, 1));
    fire(2);
    step(9);
    clear(5'h08);
    chk("cd_abort", irq_n, 1);
    cfg.per_1s_enable = 1'b1;
    fire(0);
    step(9);
    chk("tick_pulse", irq_n, 0);
    clear(5'h10);
    chk("tick_abort", irq_n, 1);
    fire(0);
    step(3);
    cfg.per_1s_enable = 1'b0;
    step(2);
    chk("tick_off", irq_n, 1);
    cfg = '0;
    $display("pulses done");
    stop_test();
  end
endmodule // tb

bind rio_irq rio_irq_chk #(.CD_W(CD_W)) i_chk (.mclk(mclk), .rstn(rstn),
  .cfg(cfg), .sec_inc(sec_inc), .countdown_event(countdown_event),
  .countdown_value(countdown_value), .watchdog_service(watchdog_service),
  .battery_low(battery_low), .flags(flags), .int_out(int_out),
  .int_oe(int_oe));
